/* core/fcs_pkg.sv */
// Package of constants and carrier types for the frame checker statistics block.
package fcs_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [15:0] FCS_ADDR_SRC_SEL   = 16'h8005;
    localparam logic [15:0] FCS_ADDR_ERR_TALLY = 16'h8008;
    localparam logic [15:0] FCS_ADDR_FRM_HIGH  = 16'h8009;
    localparam logic [15:0] FCS_ADDR_FRM_LOW   = 16'h800A;
    localparam logic [15:0] FCS_ADDR_LEN_ERR   = 16'h800B;
    localparam logic [15:0] FCS_ADDR_ALGN_ERR  = 16'h800C;
    localparam logic [15:0] FCS_ADDR_SYMB_ERR  = 16'h800D;
    localparam logic [15:0] FCS_ADDR_OVERSIZE  = 16'h800E;
    localparam logic [15:0] FCS_ADDR_UNDERSIZE = 16'h800F;
    localparam logic [15:0] FCS_ADDR_ODD_NIB   = 16'h8010;
    localparam logic [15:0] FCS_ADDR_ODD_PRE   = 16'h8011;
    localparam logic [15:0] FCS_ADDR_FALSE_CAR = 16'h8013;
    localparam logic [15:0] FCS_ADDR_GEN_EN    = 16'h8020;
    localparam logic [15:0] FCS_ADDR_MAX_FRM   = 16'h8007;

    // ------------------------------------------------------------
    // Reset values, field positions and limits
    // ------------------------------------------------------------
    localparam logic [15:0] FCS_RST_ZERO       = 16'h0000;
    localparam logic [15:0] FCS_RST_MAX_FRM    = 16'h05EE;
    localparam int          FCS_BIT_ENABLE     = 0;
    localparam logic [15:0] FCS_MIN_FRM_BYTES  = 16'h0040;
    localparam int          FCS_NUM_CAT        = 8;

    // Category indices into the error counter array.
    localparam int FCS_CAT_LEN  = 0;
    localparam int FCS_CAT_ALGN = 1;
    localparam int FCS_CAT_SYMB = 2;
    localparam int FCS_CAT_OSZ  = 3;
    localparam int FCS_CAT_USZ  = 4;
    localparam int FCS_CAT_ODD  = 5;
    localparam int FCS_CAT_PRE  = 6;
    localparam int FCS_CAT_FC   = 7;

    // Register access from the management port.
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } fcs_mgmt_req_t;

    // Per-frame status presented by the receive framer at frame end.
    typedef struct packed {
        logic        frame_end;
        logic [15:0] length;
        logic        len_err;
        logic        algn_err;
        logic        odd_nibble;
        logic        odd_preamble;
    } fcs_frame_info_t;

    // Transmit nibble stream toward the PHY.
    typedef struct packed {
        logic       en;
        logic       er;
        logic [3:0] data;
    } fcs_tx_t;

endpackage : fcs_pkg

/* core/fcs_counter_bank.sv */
// Bank of running category counters with one snapshot register per counter.
`timescale 1ns/1ps
module fcs_counter_bank
    import fcs_pkg::*;
(
    input  wire logic                      core_clk,
    input  wire logic                      rst,
    input  wire logic [FCS_NUM_CAT-1:0]    inc,
    input  wire logic                      capture,
    output      logic [FCS_NUM_CAT*16-1:0] snap
);

    typedef struct packed {
        logic [FCS_NUM_CAT-1:0][15:0] run;
        logic [FCS_NUM_CAT-1:0][15:0] snap;
    } fcs_bank_state_t;

    fcs_bank_state_t state_ff;
    fcs_bank_state_t nxt_state;

    // ------------------------------------------------------------
    // Counting and capture
    // ------------------------------------------------------------
    // Each counter advances on its event; the capture copies the value
    // including an event of the same cycle, so no event is lost.
    always_comb begin
        nxt_state = state_ff;
        for (int i = 0; i < FCS_NUM_CAT; i++) begin
            if (inc[i]) begin
                nxt_state.run[i] = state_ff.run[i] + 16'h0001;
            end
            if (capture) begin
                nxt_state.snap[i] = nxt_state.run[i];
            end
        end
    end

    // Registers the bank state.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Snapshots leave straight from flip-flops.
    assign snap = state_ff.snap;

    // Snapshots hold when no capture is requested.
    snap_hold_a: assert property (@(posedge core_clk) disable iff (rst)
        !capture |=> $stable(snap))
        else $error("snapshot changed without capture");

endmodule // fcs_counter_bank

/* core/fcs_stats.sv */
// Frame checker statistics, snapshot registers and frame generator source select.
`timescale 1ns/1ps
module fcs_stats
    import fcs_pkg::*;
(
    input  wire logic            core_clk,
    input  wire logic            rst,
    input  wire fcs_mgmt_req_t   mgmt_req,
    output      logic [15:0]     mgmt_rdata,
    output      logic            mgmt_rvalid,
    input  wire fcs_frame_info_t rx_info,
    input  wire fcs_frame_info_t txin_info,
    input  wire logic            rx_dv,
    input  wire logic            rx_er,
    input  wire logic            txin_dv,
    input  wire logic            txin_er,
    input  wire logic            bad_ssd,
    input  wire logic            rx_error_event,
    input  wire logic            diag_clk_on,
    input  wire fcs_tx_t         mac_tx,
    input  wire fcs_tx_t         gen_tx,
    output      fcs_tx_t         phy_tx,
    output      logic            gen_active
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] frames;
        logic [15:0] frames_low_snap;
        logic [15:0] frames_high_snap;
        logic [15:0] err_tally;
        logic        src_sel;
        logic        gen_en;
        logic [15:0] max_frm;
        logic        symb_seen;
        logic [15:0] rdata;
        logic        rvalid;
        fcs_tx_t     tx;
        logic        gen_active;
    } fcs_state_t;

    fcs_state_t               state_ff;
    fcs_state_t               nxt_state;
    logic [FCS_NUM_CAT-1:0]   cat_inc;
    logic [FCS_NUM_CAT*16-1:0] cat_snap;
    logic                     tally_read;
    fcs_frame_info_t          sel_info;
    logic                     sel_dv;
    logic                     sel_er;

    // Picks one category's snapshot from the flat bank output.
    function automatic logic [15:0] cat_word(input logic [FCS_NUM_CAT*16-1:0] v,
                                             input int idx);
        cat_word = v[idx*16 +: 16];
    endfunction

    // ------------------------------------------------------------
    // Source selection for the checker
    // ------------------------------------------------------------
    // Set picks frames from the MAC side bound for transmit; clear picks
    // frames received from the remote end.
    always_comb begin
        if (state_ff.src_sel) begin
            sel_info = txin_info;
            sel_dv   = txin_dv;
            sel_er   = txin_er;
        end else begin
            sel_info = rx_info;
            sel_dv   = rx_dv;
            sel_er   = rx_er;
        end
    end

    // A tally read is the trigger for the snapshot of everything.
    assign tally_read = mgmt_req.rd && (mgmt_req.addr == FCS_ADDR_ERR_TALLY);

    // Category events, one per frame end except the false carrier event.
    always_comb begin
        cat_inc               = '0;
        cat_inc[FCS_CAT_LEN]  = sel_info.frame_end && sel_info.len_err;
        cat_inc[FCS_CAT_ALGN] = sel_info.frame_end && sel_info.algn_err;
        cat_inc[FCS_CAT_SYMB] = sel_info.frame_end
                                && (state_ff.symb_seen || (sel_dv && sel_er));
        cat_inc[FCS_CAT_OSZ]  = sel_info.frame_end
                                && (sel_info.length > state_ff.max_frm);
        cat_inc[FCS_CAT_USZ]  = sel_info.frame_end
                                && (sel_info.length < FCS_MIN_FRM_BYTES);
        cat_inc[FCS_CAT_ODD]  = sel_info.frame_end && sel_info.odd_nibble;
        cat_inc[FCS_CAT_PRE]  = sel_info.frame_end && sel_info.odd_preamble;
        cat_inc[FCS_CAT_FC]   = bad_ssd;
    end

    // The bank holds the eight running counters and their snapshots.
    fcs_counter_bank u_bank (
        .core_clk (core_clk),
        .rst      (rst),
        .inc      (cat_inc),
        .capture  (tally_read),
        .snap     (cat_snap)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_state.rvalid = 1'b0;
        // Symbol error seen during the current frame.
        if (sel_dv && sel_er) begin
            nxt_state.symb_seen = 1'b1;
        end
        if (sel_info.frame_end) begin
            nxt_state.symb_seen = 1'b0;
            nxt_state.frames    = state_ff.frames + 32'h0000_0001;
        end
        // Error tally advances; a read clears it, but an event in the
        // same cycle survives as a count of one.
        if (tally_read) begin
            nxt_state.err_tally = rx_error_event ? 16'h0001 : FCS_RST_ZERO;
            nxt_state.frames_low_snap  = nxt_state.frames[15:0];
            nxt_state.frames_high_snap = nxt_state.frames[31:16];
        end else if (rx_error_event) begin
            nxt_state.err_tally = state_ff.err_tally + 16'h0001;
        end
        // Writes to the control registers.
        if (mgmt_req.wr) begin
            case (mgmt_req.addr)
                FCS_ADDR_SRC_SEL: nxt_state.src_sel = mgmt_req.wdata[FCS_BIT_ENABLE];
                FCS_ADDR_GEN_EN:  nxt_state.gen_en  = mgmt_req.wdata[FCS_BIT_ENABLE];
                FCS_ADDR_MAX_FRM: nxt_state.max_frm = mgmt_req.wdata;
                default:          nxt_state.max_frm = nxt_state.max_frm;
            endcase
        end
        // Read data, returned one cycle after the read.
        if (mgmt_req.rd) begin
            nxt_state.rvalid = 1'b1;
            case (mgmt_req.addr)
                FCS_ADDR_SRC_SEL:   nxt_state.rdata = {15'h0000, state_ff.src_sel};
                FCS_ADDR_ERR_TALLY: nxt_state.rdata = state_ff.err_tally;
                FCS_ADDR_FRM_HIGH:  nxt_state.rdata = state_ff.frames_high_snap;
                FCS_ADDR_FRM_LOW:   nxt_state.rdata = state_ff.frames_low_snap;
                FCS_ADDR_LEN_ERR:   nxt_state.rdata = cat_word(cat_snap, FCS_CAT_LEN);
                FCS_ADDR_ALGN_ERR:  nxt_state.rdata = cat_word(cat_snap, FCS_CAT_ALGN);
                FCS_ADDR_SYMB_ERR:  nxt_state.rdata = cat_word(cat_snap, FCS_CAT_SYMB);
                FCS_ADDR_OVERSIZE:  nxt_state.rdata = cat_word(cat_snap, FCS_CAT_OSZ);
                FCS_ADDR_UNDERSIZE: nxt_state.rdata = cat_word(cat_snap, FCS_CAT_USZ);
                FCS_ADDR_ODD_NIB:   nxt_state.rdata = cat_word(cat_snap, FCS_CAT_ODD);
                FCS_ADDR_ODD_PRE:   nxt_state.rdata = cat_word(cat_snap, FCS_CAT_PRE);
                FCS_ADDR_FALSE_CAR: nxt_state.rdata = cat_word(cat_snap, FCS_CAT_FC);
                FCS_ADDR_GEN_EN:    nxt_state.rdata = {15'h0000, state_ff.gen_en};
                FCS_ADDR_MAX_FRM:   nxt_state.rdata = state_ff.max_frm;
                default:            nxt_state.rdata = FCS_RST_ZERO;
            endcase
        end
        // Transmit source: generator whenever enabled; only the active flag also needs its clock.
        nxt_state.gen_active = state_ff.gen_en && diag_clk_on; // Needs the diagnostic clock.
        nxt_state.tx = state_ff.gen_en ? gen_tx : mac_tx;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_ff         <= '0;
            state_ff.max_frm <= FCS_RST_MAX_FRM;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Outputs come straight from the state register.
    assign mgmt_rdata  = state_ff.rdata;
    assign mgmt_rvalid = state_ff.rvalid;
    assign phy_tx      = state_ff.tx;
    assign gen_active  = state_ff.gen_active;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // A tally read with no error event in the same cycle.
    sequence tally_rd_s;
        tally_read && !rx_error_event;
    endsequence

    // A symbol error seen before the closing cycle of a frame.
    sequence symb_early_s;
        sel_dv && sel_er && !sel_info.frame_end;
    endsequence

    // The frame end that follows such an early symbol error.
    sequence symb_close_s;
        symb_early_s ##1 sel_info.frame_end;
    endsequence

    // A frame end offered only by the receive side while transmit is selected.
    sequence rx_ignored_s;
        state_ff.src_sel && rx_info.frame_end && !txin_info.frame_end;
    endsequence

    // A plain read of the tally clears it.
    tally_clear_a: assert property (@(posedge core_clk) disable iff (rst)
        tally_rd_s |=> (state_ff.err_tally == 16'h0000))
        else $error("tally not cleared by read");

    // The tally read returns the count held before the clear.
    tally_data_a: assert property (@(posedge core_clk) disable iff (rst)
        tally_read |=> (mgmt_rdata == $past(state_ff.err_tally)))
        else $error("tally read returned wrong count");

    // Error events advance the tally between reads.
    tally_count_a: assert property (@(posedge core_clk) disable iff (rst)
        (rx_error_event && !tally_read)
        |=> (state_ff.err_tally == $past(state_ff.err_tally) + 16'h0001))
        else $error("error event not counted");

    // Both halves of the frame count come from one capture.
    frame_snap_a: assert property (@(posedge core_clk) disable iff (rst)
        tally_read |=> ({state_ff.frames_high_snap, state_ff.frames_low_snap}
                        == state_ff.frames))
        else $error("frame snapshot differs from running count");

    // Every frame end of the selected source advances the frame count.
    frame_count_a: assert property (@(posedge core_clk) disable iff (rst)
        sel_info.frame_end |=> (state_ff.frames == $past(state_ff.frames) + 32'h0000_0001))
        else $error("frame end not counted");

    // Receive-side frames leave the count alone while the transmit side is selected.
    src_ignore_a: assert property (@(posedge core_clk) disable iff (rst)
        rx_ignored_s |=> $stable(state_ff.frames))
        else $error("unselected source frame counted");

    // The low half of the frame snapshot holds between tally reads.
    frame_hold_a: assert property (@(posedge core_clk) disable iff (rst)
        !tally_read |=> $stable(state_ff.frames_low_snap))
        else $error("frame snapshot moved without tally read");

    // The high half of the frame snapshot holds between tally reads.
    frame_high_hold_a: assert property (@(posedge core_clk) disable iff (rst)
        !tally_read |=> $stable(state_ff.frames_high_snap))
        else $error("high frame snapshot moved without tally read");

    // An early symbol error is remembered until the frame ends.
    symb_seen_a: assert property (@(posedge core_clk) disable iff (rst)
        symb_early_s |=> state_ff.symb_seen)
        else $error("early symbol error forgotten");

    // A frame that carried an early symbol error is counted at its end.
    symb_count_a: assert property (@(posedge core_clk) disable iff (rst)
        symb_close_s |-> cat_inc[FCS_CAT_SYMB])
        else $error("frame with symbol error not counted");

    // The generator source is passed on while enabled.
    tx_source_a: assert property (@(posedge core_clk) disable iff (rst)
        state_ff.gen_en |=> (phy_tx == $past(gen_tx)))
        else $error("generator enabled but MAC drives transmit");

    // The MAC source is passed on while the generator is off.
    tx_mac_a: assert property (@(posedge core_clk) disable iff (rst)
        !state_ff.gen_en |=> (phy_tx == $past(mac_tx)))
        else $error("MAC source not passed while generator off");

    // Without its clock the generator is never reported active.
    gen_idle_a: assert property (@(posedge core_clk) disable iff (rst)
        (state_ff.gen_en && !diag_clk_on) |=> !gen_active)
        else $error("generator active without its clock");

    // Short frames raise the undersize event.
    undersize_a: assert property (@(posedge core_clk) disable iff (rst)
        (sel_info.frame_end && sel_info.length < FCS_MIN_FRM_BYTES)
        |-> cat_inc[FCS_CAT_USZ])
        else $error("short frame not counted");

    // The oversize event needs a frame longer than the limit.
    oversize_a: assert property (@(posedge core_clk) disable iff (rst)
        cat_inc[FCS_CAT_OSZ] |-> (sel_info.length > state_ff.max_frm))
        else $error("oversize count without long frame");

    // Every read is answered by a single-cycle valid pulse.
    read_answer_a: assert property (@(posedge core_clk) disable iff (rst)
        mgmt_req.rd |=> mgmt_rvalid ##1 (!mgmt_rvalid || $past(mgmt_req.rd)))
        else $error("read answer missing");

endmodule // fcs_stats

/* dv/testbench.sv */
// Self-checking testbench for the frame checker statistics block.
`timescale 1ns/1ps
module testbench;
    import fcs_pkg::*;
    // ------------------------------------------------------------
    // Signals and reference model
    // ------------------------------------------------------------
    logic            core_clk;
    logic            rst;
    fcs_mgmt_req_t   mgmt_req;
    logic [15:0]     mgmt_rdata;
    logic            mgmt_rvalid;
    fcs_frame_info_t rx_info;
    fcs_frame_info_t txin_info;
    logic            rx_dv, rx_er, txin_dv, txin_er;
    logic            bad_ssd, rx_error_event, diag_clk_on, gen_active;
    fcs_tx_t         mac_tx, gen_tx, phy_tx;
    logic [15:0]     exp_q[$];
    logic [15:0]     cnt[FCS_NUM_CAT];
    logic [15:0]     snap[FCS_NUM_CAT];
    logic [31:0]     frames, frames_snap;
    logic [15:0]     tally, max_len;
    logic            sel;
    int              bad_count, n_compared, cycles;
    localparam logic [15:0] CAT_ADDR[FCS_NUM_CAT] = '{FCS_ADDR_LEN_ERR, FCS_ADDR_ALGN_ERR,
        FCS_ADDR_SYMB_ERR, FCS_ADDR_OVERSIZE, FCS_ADDR_UNDERSIZE, FCS_ADDR_ODD_NIB,
        FCS_ADDR_ODD_PRE, FCS_ADDR_FALSE_CAR};
    localparam logic [15:0] LENS[6] = '{16'h003F, 16'h0040, 16'h05EE, 16'h05EF, 16'h0064,
        16'h0065};

    fcs_stats u_dut (.core_clk(core_clk), .rst(rst), .mgmt_req(mgmt_req),
        .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .rx_info(rx_info),
        .txin_info(txin_info), .rx_dv(rx_dv), .rx_er(rx_er), .txin_dv(txin_dv),
        .txin_er(txin_er), .bad_ssd(bad_ssd), .rx_error_event(rx_error_event),
        .diag_clk_on(diag_clk_on), .mac_tx(mac_tx), .gen_tx(gen_tx), .phy_tx(phy_tx),
        .gen_active(gen_active));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    // Compares one value and counts the result.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic finish_test();
        if (bad_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Register write, one-cycle strobe.
    task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge core_clk);
        mgmt_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge core_clk);
        mgmt_req <= '0;
    endtask

    // Register read; the expected data is queued for the monitor.
    task automatic reg_rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge core_clk);
        mgmt_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
        exp_q.push_back(e);
        @(posedge core_clk);
        mgmt_req <= '0;
    endtask

    // One frame end on either source with random status and side events.
    task automatic frame(input logic src, input logic [15:0] len);
        fcs_frame_info_t f;
        logic            sym, bs, ee, pre;
        f = fcs_frame_info_t'($urandom);
        f.frame_end = 1'b1;
        f.length = len;
        sym = 1'($urandom);
        bs = 1'($urandom);
        ee = 1'($urandom);
        pre = 1'($urandom);
        // Opening cycle with data valid and perhaps an early symbol error.
        @(posedge core_clk);
        if (src) begin
            txin_dv <= 1'b1; txin_er <= pre;
        end else begin
            rx_dv <= 1'b1; rx_er <= pre;
        end
        @(posedge core_clk);
        if (src) begin
            txin_info <= f; txin_er <= sym;
        end else begin
            rx_info <= f; rx_er <= sym;
        end
        bad_ssd <= bs;
        rx_error_event <= ee;
        cnt[FCS_CAT_FC] += 16'(bs);
        tally += 16'(ee);
        if (src == sel) begin
            frames++;
            cnt[FCS_CAT_LEN] += 16'(f.len_err);
            cnt[FCS_CAT_ALGN] += 16'(f.algn_err);
            cnt[FCS_CAT_SYMB] += 16'(sym | pre);
            cnt[FCS_CAT_OSZ] += 16'(len > max_len);
            cnt[FCS_CAT_USZ] += 16'(len < FCS_MIN_FRM_BYTES);
            cnt[FCS_CAT_ODD] += 16'(f.odd_nibble);
            cnt[FCS_CAT_PRE] += 16'(f.odd_preamble);
        end
        @(posedge core_clk);
        rx_info <= '0; txin_info <= '0; bad_ssd <= 1'b0; rx_error_event <= 1'b0;
        rx_dv <= 1'b0; rx_er <= 1'b0; txin_dv <= 1'b0; txin_er <= 1'b0;
    endtask

    // Reads the tally, which clears it and freezes every snapshot.
    task automatic read_tally();
        reg_rd(FCS_ADDR_ERR_TALLY, tally);
        snap = cnt;
        frames_snap = frames;
        tally = 16'h0000;
    endtask

    // Reads both frame count halves and all category snapshots.
    task automatic read_snaps();
        reg_rd(FCS_ADDR_FRM_HIGH, frames_snap[31:16]);
        reg_rd(FCS_ADDR_FRM_LOW, frames_snap[15:0]);
        for (int i = 0; i < FCS_NUM_CAT; i++) begin
            reg_rd(CAT_ADDR[i], snap[i]);
        end
    endtask

    // ------------------------------------------------------------
    // Clock, monitor and timeout
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Takes the oldest expectation whenever read data appears.
    always @(negedge core_clk) begin
        if (mgmt_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(mgmt_rdata, 16'hXXXX, "unexpected mgmt_rvalid");
            end else begin
                check(mgmt_rdata, exp_q.pop_front(), "mgmt_rdata");
            end
        end
    end

    // Cuts a hang short well above the expected run length.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            finish_test();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1; mgmt_req = '0; rx_info = '0; txin_info = '0; rx_dv = 1'b0;
        rx_er = 1'b0; txin_dv = 1'b0; txin_er = 1'b0; bad_ssd = 1'b0;
        rx_error_event = 1'b0; diag_clk_on = 1'b0; mac_tx = '0; gen_tx = '0;
        bad_count = 0; n_compared = 0; cycles = 0; frames = '0; frames_snap = '0;
        tally = '0; max_len = FCS_RST_MAX_FRM; sel = 1'b0;
        foreach (cnt[i]) begin
            cnt[i] = '0; snap[i] = '0;
        end
        void'($urandom(39330));
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        read_snaps();
        reg_rd(FCS_ADDR_GEN_EN, FCS_RST_ZERO);
        reg_rd(FCS_ADDR_MAX_FRM, FCS_RST_MAX_FRM);
        reg_rd(16'h8030, FCS_RST_ZERO);
        for (int pass = 0; pass < 3; pass++) begin
            if (pass == 2) begin
                reg_wr(FCS_ADDR_SRC_SEL, 16'h0001);
                reg_wr(FCS_ADDR_MAX_FRM, 16'h0064);
                sel = 1'b1;
                max_len = 16'h0064;
            end
            repeat (40) frame(1'($urandom), LENS[$urandom_range(5, 0)]);
            read_tally();
            read_snaps();
            repeat (10) frame(1'($urandom), LENS[$urandom_range(5, 0)]);
            reg_wr(FCS_ADDR_LEN_ERR, 16'hFFFF);
            read_snaps();
        end
        read_tally();
        read_snaps();
        diag_clk_on <= 1'b1;
        for (int g = 0; g < 2; g++) begin
            reg_wr(FCS_ADDR_GEN_EN, 16'(g));
            reg_rd(FCS_ADDR_GEN_EN, 16'(g));
            repeat (8) begin
                @(posedge core_clk);
                mac_tx <= fcs_tx_t'($urandom);
                gen_tx <= fcs_tx_t'($urandom);
                @(posedge core_clk);
                @(negedge core_clk);
                check(16'(phy_tx), 16'(g ? gen_tx : mac_tx), "phy_tx");
                check(16'(gen_active), 16'(g), "gen_active");
            end
        end
        diag_clk_on <= 1'b0;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        check(16'(gen_active), 16'h0000, "gen_active");
        repeat (3) @(posedge core_clk);
        check(16'(exp_q.size()), 16'h0000, "pending reads");
        finish_test();
    end
endmodule // testbench
